// >>> pkg/acc_pkg.sv
// Functional notes
// - Stop mode freezes unit, registers keep contents.
// - No interrupt request wakes from stop.
// - Operation resumes after stop without software.
// - Flag-clear-allow set: break clears stick.
// - Allow clear: break accesses leave flags.
// - Enabled unit drives transmit pin as output.
// - Enabled unit makes receive pin input.
// - Loopback routes transmitter into receiver.
// - Enable clear sets empty, done; masks tx.
// - Polarity flip inverts every transmitted level.
// - Length bit selects nine or eight bits.
// - Ninth bit: stop, address mark, parity.
// - One start, one stop, listed frames.
// - Parity occupies character most significant bit.
// - Parity sense: one odd, zero even.
// - Resume select: address mark or idle.
// - Idle count starts after stop or start.
// - Empty enable lets empty flag interrupt.
// - Done enable lets done flag interrupt.
// - Full enable lets full flag interrupt.
// - Empty flag sets on shifter hand-off.
// - Done flag sets when empty and quiet.
// - Full flag sets on receive transfer.
package acc_pkg;

  // ****************************************************************
  // Register map and reset values.
  // ****************************************************************
  localparam logic [4:0] ADDR_CTRL_ONE = 5'h00;
  localparam logic [4:0] ADDR_CTRL_TWO = 5'h04;
  localparam logic [4:0] ADDR_STATUS   = 5'h08;
  localparam logic [4:0] ADDR_DATA     = 5'h0C;
  localparam logic [4:0] ADDR_BRK_CTRL = 5'h10;
  localparam logic [7:0] CTRL_ONE_RST  = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST  = 8'h00;
  localparam logic [7:0] BRK_CTRL_RST  = 8'h00;
  localparam logic [7:0] BRK_CTRL_MASK = 8'h80;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int C1_LOOP  = 7;
  localparam int C1_EN    = 6;
  localparam int C1_INV   = 5;
  localparam int C1_CHAR9 = 4;
  localparam int C1_WAKE  = 3;
  localparam int C1_IDLE_ORG = 2;
  localparam int C1_PAR_ON   = 1;
  localparam int C1_PAR_ODD  = 0;
  localparam int C2_TIE   = 7;
  localparam int C2_DONE_IE = 6;
  localparam int C2_RIE   = 5;
  localparam int C2_ILIE  = 4;
  localparam int C2_TE    = 3;
  localparam int C2_RE    = 2;
  localparam int C2_RWU   = 1;
  localparam int C2_SBK   = 0;
  localparam int BF_ALLOW = 7;

  // ****************************************************************
  // Timing and frame constants.
  // ****************************************************************
  localparam int unsigned CLK_NS  = 8;
  localparam int unsigned BIT_NS  = 8680;
  localparam logic [10:0] BIT_CYC = 11'(BIT_NS / CLK_NS);
  localparam logic [10:0] HALF_CYC = 11'(BIT_NS / CLK_NS / 2);
  localparam logic [3:0]  FRM_LEN8 = 4'hA;
  localparam logic [3:0]  FRM_LEN9 = 4'hB;

  // ****************************************************************
  // State encodings and the state record.
  // ****************************************************************
  typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} acc_tx_st_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10} acc_rx_st_t;

  typedef struct packed {
    logic [7:0]  c1;
    logic [7:0]  c2;
    logic [7:0]  bfc;
    logic        tbe;
    logic        done;
    logic        rxf;
    logic        idle;
    logic        ovr;
    logic        fe;
    logic        pe;
    logic        arm_tx;
    logic        arm_rx;
    logic        idle_ok;
    logic [8:0]  tx_data;
    logic        tx_pend;
    logic        pre_pend;
    logic        te_prev;
    logic        tx_brk;
    acc_tx_st_t  txs;
    logic [11:0] tx_sh;
    logic [3:0]  tx_cnt;
    logic [10:0] tx_tmr;
    acc_rx_st_t  rxs;
    logic [8:0]  rx_sh;
    logic [3:0]  rx_cnt;
    logic [10:0] rx_tmr;
    logic [8:0]  rx_data;
    logic [3:0]  idle_cnt;
    logic [2:0]  rx_sync;
    logic        rx_filt;
    logic        ack;
    logic [31:0] rdata;
  } acc_state_t;

endpackage

// >>> rtl/acc_serial.sv
// Register access over Avalon-MM and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module acc_serial
  import acc_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        stop_mode_i,
  input  wire logic        debug_break_i,
  input  wire logic        port_e_dir_bit_two_i,
  input  wire logic        port_e_dir_bit_one_i,
  input  wire logic        port_tx_data_i,
  input  wire logic        port_rx_data_i,
  output logic             tx_line_pin_o,
  output logic             tx_line_pin_oe_n_o,
  input  wire logic        rx_line_pin_i,
  output logic             rx_line_pin_o,
  output logic             rx_line_pin_oe_n_o,
  output logic             tx_irq_o,
  output logic             rx_irq_o
);

  // ****************************************************************
  // State record.
  // ****************************************************************
  acc_state_t q;
  acc_state_t d;

  logic       en;
  logic       acc;
  logic       brk_lock;
  logic       tx_lvl;
  logic       rx_in;
  logic [3:0] frm_len;
  logic [8:0] ch;
  logic       par;
  logic [8:0] chx;
  logic       msb;
  logic       perr;

  // The transmitter line level before any polarity flip.
  assign tx_lvl = (q.txs == TX_SHIFT) ? q.tx_sh[0] : 1'b1;

  // Pin ownership: the enabled unit takes over both port pins.
  assign tx_line_pin_o      = q.c1[C1_EN] ? (tx_lvl ^ q.c1[C1_INV]) : port_tx_data_i;
  assign tx_line_pin_oe_n_o = q.c1[C1_EN] ? 1'b0 : ~port_e_dir_bit_two_i;
  assign rx_line_pin_o      = port_rx_data_i;
  assign rx_line_pin_oe_n_o = q.c1[C1_EN] ? 1'b1 : ~port_e_dir_bit_one_i;

  // The bus stalls while stopped so no access can touch a frozen register.
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & (~q.ack | stop_mode_i);
  assign avs_readdata_o    = q.rdata;

  // Interrupt lines are masked while stopped so none can wake the core.
  assign tx_irq_o = ~stop_mode_i & q.c1[C1_EN]
                    & ((q.tbe & q.c2[C2_TIE]) | (q.done & q.c2[C2_DONE_IE]));
  assign rx_irq_o = ~stop_mode_i & ~q.c2[C2_RWU]
                    & ((q.rxf & q.c2[C2_RIE]) | (q.idle & q.c2[C2_ILIE]));

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  always_comb begin
    d        = q;
    en       = q.c1[C1_EN];
    acc      = (avs_read_i | avs_write_i) & q.ack & ~stop_mode_i;
    brk_lock = debug_break_i & ~q.bfc[BF_ALLOW];
    frm_len  = q.c1[C1_CHAR9] ? FRM_LEN9 : FRM_LEN8;
    ch       = q.tx_data;
    par      = 1'b0;
    chx      = 9'h000;
    msb      = 1'b0;
    perr     = 1'b0;

    // Bus slave: one wait cycle, then the access completes.
    d.ack = (avs_read_i | avs_write_i) & ~q.ack;
    if (avs_read_i & ~q.ack) begin
      case (avs_address_i)
        ADDR_CTRL_ONE: d.rdata = {24'h000000, q.c1};
        ADDR_CTRL_TWO: d.rdata = {24'h000000, q.c2};
        ADDR_STATUS:   d.rdata = {24'h000000, q.tbe, q.done, q.rxf, q.idle,
                                  q.ovr, 1'b0, q.fe, q.pe};
        ADDR_DATA:     d.rdata = {23'h000000, q.rx_data};
        ADDR_BRK_CTRL: d.rdata = {24'h000000, q.bfc};
        default:       d.rdata = 32'h00000000;
      endcase
    end

    // Register writes; the data write is the second step of the empty clear.
    if (acc & avs_write_i) begin
      case (avs_address_i)
        ADDR_CTRL_ONE: d.c1 = avs_writedata_i[7:0];
        ADDR_CTRL_TWO: begin
          d.c2 = avs_writedata_i[7:0];
          if (!en) begin
            d.c2[C2_TE] = q.c2[C2_TE];
            d.c2[C2_RE] = q.c2[C2_RE];
          end
        end
        ADDR_DATA: begin
          d.tx_data = avs_writedata_i[8:0];
          d.tx_pend = 1'b1;
          if (!brk_lock) begin
            if (q.arm_tx) begin
              d.tbe = 1'b0;
            end
            d.arm_tx = 1'b0;
          end
        end
        ADDR_BRK_CTRL: d.bfc = avs_writedata_i[7:0] & BRK_CTRL_MASK;
        default: d.bfc = q.bfc;
      endcase
    end

    // Reads arm both two-step clears and complete the receive one unless break protects flags.
    if (acc & avs_read_i & !brk_lock) begin
      if (avs_address_i == ADDR_STATUS) begin
        d.arm_tx = q.tbe;
        d.arm_rx = q.rxf | q.idle | q.ovr | q.fe | q.pe;
      end else if (avs_address_i == ADDR_DATA && q.arm_rx) begin
        d.rxf    = 1'b0;
        d.idle   = 1'b0;
        d.ovr    = 1'b0;
        d.fe     = 1'b0;
        d.pe     = 1'b0;
        d.arm_rx = 1'b0;
      end
    end

    // A rising transmitter enable queues a preamble of ones.
    d.te_prev = d.c2[C2_TE];
    if (d.c2[C2_TE] & ~q.te_prev) begin
      d.pre_pend = 1'b1;
    end

    // Transmitter: loads break, trailing one, preamble or character.
    if (q.txs == TX_IDLE) begin
      if (en & q.c2[C2_TE]) begin
        if (q.c2[C2_SBK]) begin
          d.tx_sh  = 12'h000;
          d.tx_cnt = frm_len;
          d.tx_brk = 1'b1;
          d.txs    = TX_SHIFT;
        end else if (q.tx_brk) begin
          d.tx_sh  = 12'hFFF;
          d.tx_cnt = 4'h1;
          d.tx_brk = 1'b0;
          d.txs    = TX_SHIFT;
        end else if (q.pre_pend) begin
          d.tx_sh    = 12'hFFF;
          d.tx_cnt   = frm_len;
          d.pre_pend = 1'b0;
          d.txs      = TX_SHIFT;
        end else if (q.tx_pend) begin
          if (q.c1[C1_CHAR9]) begin
            par = (^q.tx_data[7:0]) ^ q.c1[C1_PAR_ODD];
            if (q.c1[C1_PAR_ON]) begin
              ch[8] = par;
            end
            d.tx_sh = {2'b11, ch, 1'b0};
          end else begin
            par = (^q.tx_data[6:0]) ^ q.c1[C1_PAR_ODD];
            if (q.c1[C1_PAR_ON]) begin
              ch[7] = par;
            end
            d.tx_sh = {3'b111, ch[7:0], 1'b0};
          end
          d.tx_cnt  = frm_len;
          d.tx_pend = 1'b0;
          d.tbe     = 1'b1;
          d.txs     = TX_SHIFT;
        end
      end
      d.tx_tmr = 11'h000;
    end else begin
      if (q.tx_tmr == BIT_CYC - 11'h001) begin
        d.tx_tmr = 11'h000;
        d.tx_sh  = {1'b1, q.tx_sh[11:1]};
        d.tx_cnt = q.tx_cnt - 4'h1;
        if (q.tx_cnt == 4'h1) begin
          d.txs = TX_IDLE;
        end
      end else begin
        d.tx_tmr = q.tx_tmr + 11'h001;
      end
    end

    // Receiver input: a change counts once the last two stages agree.
    d.rx_sync = {q.rx_sync[1:0], rx_line_pin_i};
    if (q.rx_sync[1] == q.rx_sync[2]) begin
      d.rx_filt = q.rx_sync[2];
    end
    rx_in = q.c1[C1_LOOP] ? tx_lvl : q.rx_filt;

    // Receiver: start detect, mid-bit sampling, transfer on the stop bit.
    if (en & q.c2[C2_RE]) begin
      case (q.rxs)
        RX_IDLE: begin
          if (!rx_in) begin
            d.rxs      = RX_START;
            d.rx_tmr   = 11'h000;
            d.idle_cnt = 4'h0;
          end else if (q.rx_tmr == BIT_CYC - 11'h001) begin
            d.rx_tmr = 11'h000;
            if (q.idle_cnt < frm_len) begin
              d.idle_cnt = q.idle_cnt + 4'h1;
            end
          end else begin
            d.rx_tmr = q.rx_tmr + 11'h001;
          end
        end
        RX_START: begin
          if (q.rx_tmr == HALF_CYC) begin
            d.rx_tmr = 11'h000;
            d.rx_cnt = 4'h0;
            d.rxs    = rx_in ? RX_IDLE : RX_DATA;
          end else begin
            d.rx_tmr = q.rx_tmr + 11'h001;
          end
        end
        RX_DATA: begin
          if (q.rx_tmr == BIT_CYC - 11'h001) begin
            d.rx_tmr = 11'h000;
            if (!q.c1[C1_IDLE_ORG]) begin
              d.idle_cnt = rx_in ? q.idle_cnt + 4'h1 : 4'h0;
            end
            if (q.rx_cnt < frm_len - 4'h2) begin
              d.rx_sh  = {rx_in, q.rx_sh[8:1]};
              d.rx_cnt = q.rx_cnt + 4'h1;
            end else begin
              d.rxs = RX_IDLE;
              chx   = q.c1[C1_CHAR9] ? q.rx_sh : {q.rx_sh[8], q.rx_sh[8:1]};
              msb   = q.c1[C1_CHAR9] ? q.rx_sh[8] : q.rx_sh[8];
              perr  = q.c1[C1_PAR_ON] & ((q.c1[C1_CHAR9] ? ^q.rx_sh : ^q.rx_sh[8:1])
                      ^ q.c1[C1_PAR_ODD]);
              if (q.c2[C2_RWU] & q.c1[C1_WAKE] & msb) begin
                d.c2[C2_RWU] = 1'b0;
              end
              if (!d.c2[C2_RWU]) begin
                if (d.rxf) begin
                  d.ovr = 1'b1;
                end else begin
                  d.rx_data = chx;
                  d.rxf     = 1'b1;
                  d.fe      = ~rx_in;
                  d.pe      = perr;
                  d.idle_ok = 1'b1;
                end
              end
            end
          end else begin
            d.rx_tmr = q.rx_tmr + 11'h001;
          end
        end
        default: d.rxs = RX_IDLE;
      endcase
      // A run of ones as long as a frame counts as an idle character.
      if (d.idle_cnt == frm_len && q.idle_cnt != frm_len) begin
        if (q.c2[C2_RWU] & ~q.c1[C1_WAKE]) begin
          d.c2[C2_RWU] = 1'b0;
        end else if (q.idle_ok & ~q.c2[C2_RWU]) begin
          d.idle    = 1'b1;
          d.idle_ok = 1'b0;
        end
      end
    end else begin
      d.rxs      = RX_IDLE;
      d.idle_cnt = 4'h0;
    end

    // Done follows empty whenever nothing is queued or shifting.
    if (d.txs == TX_SHIFT || d.tx_pend || d.pre_pend || d.c2[C2_SBK] || d.tx_brk) begin
      d.done = 1'b0;
    end else if (d.tbe) begin
      d.done = 1'b1;
    end

    // A disabled unit is idle with its transmit flags forced set.
    if (!d.c1[C1_EN]) begin
      d.tbe      = 1'b1;
      d.done     = 1'b1;
      d.txs      = TX_IDLE;
      d.tx_pend  = 1'b0;
      d.pre_pend = 1'b0;
      d.tx_brk   = 1'b0;
      d.rxs      = RX_IDLE;
    end

    // Stop mode holds every bit; work resumes on the first running cycle.
    if (stop_mode_i) begin
      d = q;
    end
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      q         <= '0;
      q.c1      <= CTRL_ONE_RST;
      q.c2      <= CTRL_TWO_RST;
      q.bfc     <= BRK_CTRL_RST;
      q.tbe     <= 1'b1;
      q.done    <= 1'b1;
      q.txs     <= TX_IDLE;
      q.rxs     <= RX_IDLE;
      q.rx_sync <= 3'h7;
      q.rx_filt <= 1'b1;
    end else begin
      q <= d;
    end
  end

endmodule
`default_nettype wire

// >>> tb/acc_node.sv
`timescale 1ns/1ns
`default_nettype none
module acc_node
  import acc_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic tx_line_i,
  output var logic  rx_line_o
);
  // ****************************************************************
  // Far serial node: sends characters and samples the transmit line.
  // ****************************************************************

  // The line idles high, as a released line with its pull-up.
  initial rx_line_o = 1'b1;

  // One start bit, n data bits LSB first, one stop bit.
  task automatic send_char(input logic [8:0] data, input int n);
    rx_line_o <= 1'b0;
    repeat (BIT_CYC) @(posedge core_clk_i);
    for (int i = 0; i < n; i++) begin
      rx_line_o <= data[i];
      repeat (BIT_CYC) @(posedge core_clk_i);
    end
    rx_line_o <= 1'b1;
    repeat (BIT_CYC) @(posedge core_clk_i);
  endtask

  // Forces the line level, used to show that loopback ignores the pin.
  task automatic hold_line(input logic lvl);
    rx_line_o <= lvl;
  endtask

  // Samples eleven bit centres from the start bit on.
  task automatic capture(output logic [10:0] bits);
    @(negedge tx_line_i);
    repeat (HALF_CYC) @(posedge core_clk_i);
    for (int i = 0; i < 11; i++) begin
      bits[i] = tx_line_i;
      repeat (BIT_CYC) @(posedge core_clk_i);
    end
  endtask
endmodule
`default_nettype wire

// >>> tb/acc_serial_props.sv
`timescale 1ns/1ns
`default_nettype none
module acc_chk
  import acc_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        sys_rst_i,
  input wire logic [4:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic        avs_waitrequest_o,
  input wire logic        stop_mode_i,
  input wire logic        port_e_dir_bit_two_i,
  input wire logic        port_e_dir_bit_one_i,
  input wire logic        port_tx_data_i,
  input wire logic        tx_line_pin_o,
  input wire logic        tx_line_pin_oe_n_o,
  input wire logic        rx_line_pin_oe_n_o,
  input wire logic        tx_irq_o,
  input wire logic        rx_irq_o
);
  // ****************************************************************
  // Control register shadows and port checks.
  // ****************************************************************
  logic [7:0] c1_q;
  logic [7:0] c2_q;
  logic       wr_done;

  // A write lands at the edge where waitrequest is seen low.
  assign wr_done = avs_write_i && !avs_waitrequest_o;

  // Shadows follow completed writes so the checks know the enables.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      c1_q <= 8'h00;
      c2_q <= 8'h00;
    end else if (wr_done && avs_address_i == ADDR_CTRL_ONE) begin
      c1_q <= avs_writedata_i[7:0];
    end else if (wr_done && avs_address_i == ADDR_CTRL_TWO) begin
      c2_q <= avs_writedata_i[7:0];
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  tx_pin_own_a: assert property (c1_q[C1_EN] |-> !tx_line_pin_oe_n_o)
    else $error("transmit pin not driven while the unit is on");
  rx_pin_own_a: assert property (c1_q[C1_EN] |-> rx_line_pin_oe_n_o)
    else $error("receive pin not an input while the unit is on");
  port_dir_a: assert property (!c1_q[C1_EN] |->
    (tx_line_pin_oe_n_o == !port_e_dir_bit_two_i) && (rx_line_pin_oe_n_o == !port_e_dir_bit_one_i))
    else $error("pin direction ignores the port bits while the unit is off");
  port_data_a: assert property (!c1_q[C1_EN] |-> tx_line_pin_o == port_tx_data_i)
    else $error("transmit pin does not follow port data while the unit is off");
  stop_irq_a: assert property (stop_mode_i |-> !tx_irq_o && !rx_irq_o)
    else $error("interrupt request raised in stop mode");
  stop_stall_a: assert property (stop_mode_i && (avs_read_i || avs_write_i) |-> avs_waitrequest_o)
    else $error("bus access completed in stop mode");
  tx_mask_a: assert property (!c1_q[C1_EN] |-> !tx_irq_o)
    else $error("transmit interrupt while the unit is off");
  tx_irq_src_a: assert property (tx_irq_o |-> c2_q[C2_TIE] || c2_q[C2_DONE_IE])
    else $error("transmit interrupt without an enable");
  rx_irq_src_a: assert property (rx_irq_o |-> c2_q[C2_RIE] || c2_q[C2_ILIE])
    else $error("receive interrupt without an enable");
  bus_resume_a: assert property ($rose(avs_read_i || avs_write_i) && !stop_mode_i
    ##1 !stop_mode_i |-> !avs_waitrequest_o)
    else $error("access not answered in its second cycle");
endmodule

bind acc_serial acc_chk u_chk (
  .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_waitrequest_o(avs_waitrequest_o), .stop_mode_i(stop_mode_i),
  .port_e_dir_bit_two_i(port_e_dir_bit_two_i), .port_e_dir_bit_one_i(port_e_dir_bit_one_i),
  .port_tx_data_i(port_tx_data_i), .tx_line_pin_o(tx_line_pin_o),
  .tx_line_pin_oe_n_o(tx_line_pin_oe_n_o), .rx_line_pin_oe_n_o(rx_line_pin_oe_n_o),
  .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o));
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import acc_pkg::*;
;
  // ****************************************************************
  // Bench signals, design, partner node and scenarios.
  // ****************************************************************
  logic        core_clk, sys_rst, avs_read, avs_write, stop_mode, dbg_brk;
  logic        dir_two, dir_one, port_tx, port_rx, waitreq, tx_pin, tx_oe_n;
  logic        rx_oe_n, rx_in, tx_irq, rx_irq, rx_pout;
  logic [4:0]  avs_addr;
  logic [31:0] avs_wdata, avs_rdata;
  int          miscompares, cmp_count;

  acc_serial dut (
    .core_clk_i(core_clk), .sys_rst_i(sys_rst), .avs_address_i(avs_addr),
    .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_wdata),
    .avs_readdata_o(avs_rdata), .avs_waitrequest_o(waitreq), .stop_mode_i(stop_mode),
    .debug_break_i(dbg_brk), .port_e_dir_bit_two_i(dir_two), .port_e_dir_bit_one_i(dir_one),
    .port_tx_data_i(port_tx), .port_rx_data_i(port_rx), .tx_line_pin_o(tx_pin),
    .tx_line_pin_oe_n_o(tx_oe_n), .rx_line_pin_i(rx_in), .rx_line_pin_o(rx_pout),
    .rx_line_pin_oe_n_o(rx_oe_n), .tx_irq_o(tx_irq), .rx_irq_o(rx_irq));

  acc_node u_node (.core_clk_i(core_clk), .tx_line_i(tx_pin), .rx_line_o(rx_in));

  // Free-running 125 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk1(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask

  // Bus master: hold the request until waitrequest is seen low.
  task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_addr <= a;
    avs_wdata <= d;
    avs_write <= 1'b1;
    do @(posedge core_clk); while (waitreq !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge core_clk);
    avs_addr <= a;
    avs_read <= 1'b1;
    do @(posedge core_clk); while (waitreq !== 1'b0);
    d = avs_rdata;
    avs_read <= 1'b0;
  endtask

  task automatic rd_chk(input string n, input logic [4:0] a, input logic [31:0] e);
    logic [31:0] d;
    bus_rd(a, d);
    chk(n, e, d);
  endtask

  task automatic t_reset_regs();
    rd_chk("ctrl_one", ADDR_CTRL_ONE, 32'h0);
    rd_chk("ctrl_two", ADDR_CTRL_TWO, 32'h0);
    rd_chk("status", ADDR_STATUS, 32'hC0);
    rd_chk("brk_ctrl", ADDR_BRK_CTRL, 32'h0);
    rd_chk("unmapped", 5'h14, 32'h0);
    bus_wr(ADDR_CTRL_ONE, 32'hBF);
    rd_chk("ctrl_one rw", ADDR_CTRL_ONE, 32'hBF);
    bus_wr(ADDR_CTRL_ONE, 32'h0);
  endtask

  task automatic t_pins();
    dir_two <= 1'b0;
    dir_one <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk1("tx oe off", 1'b1, tx_oe_n);
    chk1("tx pin port", 1'b0, tx_pin);
    chk1("rx pin port", 1'b0, rx_pout);
    bus_wr(ADDR_CTRL_ONE, 32'h60);
    @(posedge core_clk);
    chk1("tx oe on", 1'b0, tx_oe_n);
    chk1("rx oe on", 1'b1, rx_oe_n);
    chk1("tx idle flip", 1'b0, tx_pin);
    bus_wr(ADDR_CTRL_ONE, 32'h40);
    @(posedge core_clk);
    chk1("tx idle", 1'b1, tx_pin);
  endtask

  task automatic t_irq();
    bus_wr(ADDR_CTRL_TWO, 32'h80);
    @(posedge core_clk);
    chk1("irq empty", 1'b1, tx_irq);
    bus_wr(ADDR_CTRL_TWO, 32'h40);
    @(posedge core_clk);
    chk1("irq done", 1'b1, tx_irq);
    bus_wr(ADDR_CTRL_TWO, 32'h20);
    @(posedge core_clk);
    chk1("irq tx off", 1'b0, tx_irq);
    chk1("irq rx empty", 1'b0, rx_irq);
    bus_wr(ADDR_CTRL_TWO, 32'hC0);
    bus_wr(ADDR_CTRL_ONE, 32'h0);
    @(posedge core_clk);
    chk1("irq disabled", 1'b0, tx_irq);
    rd_chk("status off", ADDR_STATUS, 32'hC0);
  endtask

  // Stop is entered only while the line is quiet.
  task automatic t_stop();
    logic [31:0] d;
    bus_wr(ADDR_CTRL_ONE, 32'h40);
    stop_mode <= 1'b1;
    avs_addr <= ADDR_CTRL_ONE;
    avs_read <= 1'b1;
    repeat (20) @(posedge core_clk);
    chk1("stop stall", 1'b1, waitreq);
    chk1("stop irq", 1'b0, tx_irq);
    stop_mode <= 1'b0;
    do @(posedge core_clk); while (waitreq !== 1'b0);
    d = avs_rdata;
    avs_read <= 1'b0;
    chk("stop kept", 32'h40, d);
    @(posedge core_clk);
    chk1("irq resumed", 1'b1, tx_irq);
  endtask

  task automatic t_tx_frame();
    logic [31:0] d;
    logic [10:0] fr;
    bus_wr(ADDR_CTRL_ONE, 32'h42);
    bus_wr(ADDR_CTRL_TWO, 32'h08);
    bus_rd(ADDR_STATUS, d);
    bus_wr(ADDR_DATA, 32'h07);
    u_node.capture(fr);
    chk("tx frame", 32'h70E, 32'(fr));
    rd_chk("tx end", ADDR_STATUS, 32'hC0);
  endtask

  task automatic t_rx_break0();
    logic [31:0] d;
    bus_wr(ADDR_CTRL_ONE, 32'h40);
    bus_wr(ADDR_CTRL_TWO, 32'h24);
    @(posedge core_clk);
    u_node.send_char(9'h0A5, 8);
    chk1("rx irq", 1'b1, rx_irq);
    bus_rd(ADDR_STATUS, d);
    chk("rx full", 32'hE0, d);
    dbg_brk <= 1'b1;
    rd_chk("brk status", ADDR_STATUS, 32'hE0);
    rd_chk("brk data", ADDR_DATA, 32'h1A5);
    rd_chk("brk held", ADDR_STATUS, 32'hE0);
    dbg_brk <= 1'b0;
    rd_chk("rx data", ADDR_DATA, 32'h1A5);
    rd_chk("rx cleared", ADDR_STATUS, 32'hC0);
  endtask

  task automatic t_loop_break1();
    logic [31:0] d;
    bus_wr(ADDR_BRK_CTRL, 32'h80);
    bus_wr(ADDR_CTRL_ONE, 32'hD3);
    u_node.hold_line(1'b0);
    bus_wr(ADDR_CTRL_TWO, 32'h2C);
    bus_rd(ADDR_STATUS, d);
    bus_wr(ADDR_DATA, 32'h0C3);
    while (rx_irq !== 1'b1) @(posedge core_clk);
    repeat (BIT_CYC) @(posedge core_clk);
    dbg_brk <= 1'b1;
    rd_chk("loop status", ADDR_STATUS, 32'hF0);
    rd_chk("loop data", ADDR_DATA, 32'h1C3);
    dbg_brk <= 1'b0;
    rd_chk("brk cleared", ADDR_STATUS, 32'hC0);
    u_node.hold_line(1'b1);
  endtask

  // Hang guard sized above the longest expected run.
  initial begin
    repeat (90000) @(posedge core_clk);
    miscompares++;
    summarize();
  end

  // Main sequence.
  initial begin
    {sys_rst, dir_two, dir_one} = 3'h7;
    {avs_read, avs_write, stop_mode, dbg_brk, port_tx, port_rx} = 6'h0;
    avs_addr = 5'h0;
    avs_wdata = 32'h0;
    miscompares = 0;
    cmp_count = 0;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset_regs();
    t_pins();
    t_irq();
    t_stop();
    t_tx_frame();
    t_rx_break0();
    t_loop_break1();
    summarize();
  end
endmodule
`default_nettype wire
